// ### rtl/pwg_top.sv
// ahb-lite pwm generator: counter, comparators, actions, dead-band, output stage
`timescale 1ns/1ps
module pwg_top
    import pwg_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // clock divider setup from system control
    input  wire logic [2:0]  clock_divider_code,
    input  wire logic        clock_divider_use,
    // fault input
    input  wire logic        fault_in,
    // pins
    output logic             output_a_pin,
    output logic             output_b_pin
);
    // bus state
    logic             dph_act;
    logic             dph_wr;
    logic [11:0]      dph_addr;
    // registers
    logic             pending_update_commit;
    logic             counter_restart_gen0;
    logic [1:0]       output_gate;
    logic [1:0]       output_polarity;
    logic [1:0]       fault_output_handling;
    logic [1:0]       module_irq_enable;
    logic             fault_latched;
    logic [5:0]       gen0_control;
    logic [EV_W-1:0]  gen0_irq_enable;
    logic [EV_W-1:0]  gen0_irq_raw;
    logic [CNT_W-1:0] shadow_load;
    logic [CNT_W-1:0] shadow_cmpa;
    logic [CNT_W-1:0] shadow_cmpb;
    logic [11:0]      gen0_actions_a;
    logic [11:0]      gen0_actions_b;
    logic             db_enable;
    logic [DB_W-1:0]  db_rise;
    logic [DB_W-1:0]  db_fall;
    // timing state
    logic [5:0]       div_cnt;
    logic [CNT_W-1:0] cnt;
    logic             dir_up;
    logic [CNT_W-1:0] act_load;
    logic [CNT_W-1:0] act_cmpa;
    logic [CNT_W-1:0] act_cmpb;
    logic             gen_a;
    logic             gen_b;

    // bus decode
    wire        accept   = hsel && htrans[1] && hready;
    wire        wr_en    = dph_act && dph_wr;
    wire        wr_mctl  = wr_en && (dph_addr == OFF_MCTL);
    wire        wr_sync  = wr_en && (dph_addr == OFF_SYNC);
    wire        wr_gate  = wr_en && (dph_addr == OFF_GATE);
    wire        wr_pol   = wr_en && (dph_addr == OFF_POL);
    wire        wr_fault = wr_en && (dph_addr == OFF_FAULT);
    wire        wr_mien  = wr_en && (dph_addr == OFF_MIEN);
    wire        wr_misc  = wr_en && (dph_addr == OFF_MISC);
    wire        wr_gctl  = wr_en && (dph_addr == OFF_GCTL);
    wire        wr_gien  = wr_en && (dph_addr == OFF_GIEN);
    wire        wr_gisc  = wr_en && (dph_addr == OFF_GISC);
    wire        wr_load  = wr_en && (dph_addr == OFF_LOAD);
    wire        wr_cmpa  = wr_en && (dph_addr == OFF_CMPA);
    wire        wr_cmpb  = wr_en && (dph_addr == OFF_CMPB);
    wire        wr_acta  = wr_en && (dph_addr == OFF_ACTA);
    wire        wr_actb  = wr_en && (dph_addr == OFF_ACTB);
    wire        wr_dbctl = wr_en && (dph_addr == OFF_DBCTL);
    wire        wr_dbr   = wr_en && (dph_addr == OFF_DBRISE);
    wire        wr_dbf   = wr_en && (dph_addr == OFF_DBFALL);

    // interrupt status views
    wire [EV_W-1:0] gen_isc  = gen0_irq_raw & gen0_irq_enable;
    wire [31:0]     mraw     = {15'h0, fault_latched, 15'h0, |gen_isc};
    wire [31:0]     misc     = mraw & {15'h0, module_irq_enable[1], 15'h0, module_irq_enable[0]};

    // read mux; unmapped and reserved bits read zero
    wire [31:0] rd_mux =
        (dph_addr == OFF_MCTL)   ? {31'h0, pending_update_commit} :
        (dph_addr == OFF_SYNC)   ? {31'h0, counter_restart_gen0} :
        (dph_addr == OFF_GATE)   ? {30'h0, output_gate} :
        (dph_addr == OFF_POL)    ? {30'h0, output_polarity} :
        (dph_addr == OFF_FAULT)  ? {30'h0, fault_output_handling} :
        (dph_addr == OFF_MIEN)   ? {15'h0, module_irq_enable[1], 15'h0, module_irq_enable[0]} :
        (dph_addr == OFF_MRAW)   ? mraw :
        (dph_addr == OFF_MISC)   ? misc :
        (dph_addr == OFF_FLVL)   ? {31'h0, fault_in} :
        (dph_addr == OFF_GCTL)   ? {26'h0, gen0_control} :
        (dph_addr == OFF_GIEN)   ? {26'h0, gen0_irq_enable} :
        (dph_addr == OFF_GRAW)   ? {26'h0, gen0_irq_raw} :
        (dph_addr == OFF_GISC)   ? {26'h0, gen_isc} :
        (dph_addr == OFF_LOAD)   ? {16'h0, shadow_load} :
        (dph_addr == OFF_COUNT)  ? {16'h0, cnt} :
        (dph_addr == OFF_CMPA)   ? {16'h0, shadow_cmpa} :
        (dph_addr == OFF_CMPB)   ? {16'h0, shadow_cmpb} :
        (dph_addr == OFF_ACTA)   ? {20'h0, gen0_actions_a} :
        (dph_addr == OFF_ACTB)   ? {20'h0, gen0_actions_b} :
        (dph_addr == OFF_DBCTL)  ? {31'h0, db_enable} :
        (dph_addr == OFF_DBRISE) ? {20'h0, db_rise} :
        (dph_addr == OFF_DBFALL) ? {20'h0, db_fall} : 32'h0;

    // one wait state per transfer: writes land in the wait cycle, so reads never go stale
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_act   <= 1'b0;
            dph_wr    <= 1'b0;
            dph_addr  <= 12'h000;
            hreadyout <= 1'b1;
            hrdata    <= REG_RESET;
            hresp     <= 1'b0;
        end else if (dph_act) begin
            dph_act   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= dph_wr ? REG_RESET : rd_mux;
        end else if (accept) begin
            dph_act   <= 1'b1;
            dph_wr    <= hwrite;
            dph_addr  <= haddr[11:0];
            hreadyout <= 1'b0;
        end
    end

    // divided counter clock as a tick
    wire [2:0] div_sh   = (clock_divider_code > DIV_MAX_SH) ? 3'h0
                                                            : DIV_MAX_SH - clock_divider_code;
    wire [5:0] div_mask = DIV_FULL >> div_sh;
    wire       tick     = !clock_divider_use || ((div_cnt & div_mask) == div_mask);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            div_cnt <= 6'h00;
        else
            div_cnt <= div_cnt + 6'h01;
    end

    // update points: queued values move to the active set only at counter zero
    wire apply_pt = tick && (cnt == '0);
    wire load_go  = apply_pt && (!gen0_control[CTL_LOADUPD] || pending_update_commit);
    wire cmpa_go  = apply_pt && (!gen0_control[CTL_CMPAUPD] || pending_update_commit);
    wire cmpb_go  = apply_pt && (!gen0_control[CTL_CMPBUPD] || pending_update_commit);
    wire [CNT_W-1:0] load_eff = load_go ? shadow_load : act_load;
    wire             run      = gen0_control[CTL_RUN];
    wire             updown   = gen0_control[CTL_UPDOWN];

    // counter events
    wire ev_zero = tick && run && (cnt == '0);
    wire ev_load = tick && run && (cnt == act_load);
    wire hit_a   = tick && run && (cnt == act_cmpa) && (act_cmpa <= act_load)
                   && !ev_zero && !ev_load;
    wire hit_b   = tick && run && (cnt == act_cmpb) && (act_cmpb <= act_load)
                   && !ev_zero && !ev_load;
    wire up_q    = updown && dir_up;
    wire [EV_W-1:0] events = {hit_b && !up_q, hit_b && up_q, hit_a && !up_q,
                              hit_a && up_q, ev_load, ev_zero};

    // next counter value
    logic [CNT_W-1:0] next_cnt;
    logic             next_dir;
    always_comb begin
        next_cnt = cnt;
        next_dir = dir_up;
        if (tick && counter_restart_gen0) begin
            next_cnt = '0;
            next_dir = 1'b1;
        end else if (tick && run) begin
            if (!updown) begin
                next_dir = 1'b0;
                next_cnt = (cnt == '0) ? load_eff : cnt - 16'h0001;
            end else if (dir_up) begin
                if (cnt >= load_eff) begin
                    next_dir = 1'b0;
                    next_cnt = (load_eff == '0) ? '0 : load_eff - 16'h0001;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end else if (cnt == '0) begin
                next_dir = 1'b1;
                next_cnt = (load_eff == '0) ? '0 : 16'h0001;
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end
    end

    // action engine: later events in the list take precedence
    function automatic logic act_step(input logic cur, input logic [1:0] code);
        logic r;
        r = cur;
        case (code)
            ACT_KEEP:   r = cur;
            ACT_TOGGLE: r = !cur;
            ACT_LOW:    r = 1'b0;
            default:    r = 1'b1;
        endcase
        return r;
    endfunction

    function automatic logic act_apply(input logic cur, input logic [11:0] acts,
                                       input logic [EV_W-1:0] ev);
        logic r;
        r = cur;
        for (int k = 0; k < EV_W; k++) begin
            if (ev[k])
                r = act_step(r, acts[2*k +: 2]);
        end
        return r;
    endfunction

    // A only sees A matches, B only sees B matches
    wire [EV_W-1:0] ev_a = events & 6'h0f;
    wire [EV_W-1:0] ev_b = events & 6'h33;
    wire next_gen_a = act_apply(gen_a, gen0_actions_a, ev_a);
    wire next_gen_b = act_apply(gen_b, gen0_actions_b, ev_b);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt      <= '0;
            dir_up   <= 1'b0;
            act_load <= '0;
            act_cmpa <= '0;
            act_cmpb <= '0;
            gen_a    <= 1'b0;
            gen_b    <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            dir_up   <= next_dir;
            act_load <= load_eff;
            act_cmpa <= cmpa_go ? shadow_cmpa : act_cmpa;
            act_cmpb <= cmpb_go ? shadow_cmpb : act_cmpb;
            gen_a    <= next_gen_a;
            gen_b    <= next_gen_b;
        end
    end

    // software registers; all reset to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_update_commit <= 1'b0;
            counter_restart_gen0  <= 1'b0;
            output_gate           <= 2'h0;
            output_polarity       <= 2'h0;
            fault_output_handling <= 2'h0;
            module_irq_enable     <= 2'h0;
            fault_latched         <= 1'b0;
            gen0_control          <= 6'h00;
            gen0_irq_enable       <= '0;
            gen0_irq_raw          <= '0;
            shadow_load           <= '0;
            shadow_cmpa           <= '0;
            shadow_cmpb           <= '0;
            gen0_actions_a        <= 12'h000;
            gen0_actions_b        <= 12'h000;
            db_enable             <= 1'b0;
            db_rise               <= '0;
            db_fall               <= '0;
        end else begin
            if (wr_mctl && hwdata[0])
                pending_update_commit <= 1'b1;
            else if (apply_pt)
                pending_update_commit <= 1'b0;
            if (wr_sync && hwdata[0])
                counter_restart_gen0 <= 1'b1;
            else if (tick)
                counter_restart_gen0 <= 1'b0;
            if (fault_in)
                fault_latched <= 1'b1;
            else if (wr_misc && hwdata[MI_FAULT])
                fault_latched <= 1'b0;
            gen0_irq_raw <= events | (gen0_irq_raw & ~(wr_gisc ? hwdata[EV_W-1:0] : 6'h00));
            if (wr_gate)
                output_gate <= hwdata[1:0];
            if (wr_pol)
                output_polarity <= hwdata[1:0];
            if (wr_fault)
                fault_output_handling <= hwdata[1:0];
            if (wr_mien)
                module_irq_enable <= {hwdata[MI_FAULT], hwdata[MI_GEN0]};
            if (wr_gctl)
                gen0_control <= hwdata[5:0];
            if (wr_gien)
                gen0_irq_enable <= hwdata[EV_W-1:0];
            if (wr_load)
                shadow_load <= hwdata[CNT_W-1:0];
            if (wr_cmpa)
                shadow_cmpa <= hwdata[CNT_W-1:0];
            if (wr_cmpb)
                shadow_cmpb <= hwdata[CNT_W-1:0];
            if (wr_acta)
                gen0_actions_a <= hwdata[11:0];
            if (wr_actb)
                gen0_actions_b <= hwdata[11:0];
            if (wr_dbctl)
                db_enable <= hwdata[0];
            if (wr_dbr)
                db_rise <= hwdata[DB_W-1:0];
            if (wr_dbf)
                db_fall <= hwdata[DB_W-1:0];
        end
    end

    // dead-band and output stage per channel
    wire [1:0] gen_sig = {gen_b, gen_a};
    wire [1:0] db_src  = {!gen_a, gen_a};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_out
            logic [DB_W-1:0] dly;
            logic            db_out;
            logic            pin_r;
            wire  [DB_W-1:0] lim   = (ch == 0) ? db_rise : db_fall;
            wire             done  = (dly >= lim);
            wire             raw   = db_enable ? db_out : gen_sig[ch];
            wire             gated = raw && output_gate[ch];
            wire             safe  = gated && !(fault_in && fault_output_handling[ch]);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    dly    <= '0;
                    db_out <= 1'b0;
                    pin_r  <= 1'b0;
                end else begin
                    if (!db_src[ch]) begin
                        dly    <= '0;
                        db_out <= 1'b0;
                    end else if (tick && !done) begin
                        dly <= dly + 12'h001;
                    end else if (done) begin
                        db_out <= 1'b1;
                    end
                    pin_r <= safe ^ output_polarity[ch];
                end
            end
        end
    endgenerate

    assign output_a_pin = g_out[0].pin_r;
    assign output_b_pin = g_out[1].pin_r;

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire div2_cond = clock_divider_use && (clock_divider_code == DIV_BY2);
    sequence s_bus_take;
        accept && !dph_act;
    endsequence
    sequence s_bus_done;
        !hreadyout ##1 hreadyout;
    endsequence

    a_div_half_rate: assert property (div2_cond && $past(div2_cond) && $past(div2_cond, 2)
        && $past(tick, 2) |-> tick && !$past(tick)) else $error("divide by two broken");
    a_sync_restart: assert property (counter_restart_gen0 && tick |=> cnt == '0)
        else $error("counter not restarted");
    a_sync_selfclr: assert property (counter_restart_gen0 && tick && !wr_sync
        |=> !counter_restart_gen0) else $error("sync bit stuck");
    a_commit_clear: assert property (pending_update_commit && apply_pt && !wr_mctl
        |=> !pending_update_commit && act_load == $past(shadow_load))
        else $error("commit not applied");
    a_reload_down: assert property (tick && run && !updown && cnt == '0
        && !counter_restart_gen0 |=> cnt == $past(load_eff)) else $error("no reload");
    a_cmp_over: assert property (act_cmpa > act_load |-> !hit_a)
        else $error("match above period");
    a_match_zero: assert property (ev_zero || ev_load |-> !hit_a && !hit_b)
        else $error("match not masked");
    a_gate_off: assert property (!output_gate[0] && !output_polarity[0]
        |=> !output_a_pin) else $error("gated output leaked");
    a_gate_pass: assert property (output_gate[0] && !output_polarity[0] && !db_enable
        && !fault_in |=> output_a_pin == $past(gen_a)) else $error("output not passed");
    a_bus_wait: assert property (s_bus_take |=> s_bus_done) else $error("bus timing");
endmodule // pwg_top

// ### shared/pwg_pkg.sv
// constants, register map and field layout for the pwm generator block
// Contract
// - divider code 000 with divider use gives counter clock of system clock/2
// - period 0x18f, action 0x8c, compare 0x12b yields 25 percent duty on A
// - same period, action 0x80c, compare 0x63 yields 75 percent duty on B
// - generator control bit 0 starts the counter
// - registers decoded as byte offsets: module 0x000-0x020, generator 0x040-0x070
// - every register resets to zero: outputs off, counter stopped, interrupts disabled
// - commit bit applies queued load and compare updates at next counter zero
// - commit bit self-clears after applying updates; software writing zero does nothing
// - writing 1 to counter sync resets the generator counter to zero
// - counter sync bit self-clears after the counter reset happens
// - output gate set passes generated signal; clear passes constant zero to polarity
// - clearing an output gate leaves generator counting and signal unchanged
// - status-and-clear registers clear latched bits on write 1; raw and counter read-only
// - reserved bits ignore writes and read as zero
// - count-down counter decrements from period to zero then reloads period
// - compare value above period never produces a match
// - new period and compare values take effect only at counter zero
// - matches coinciding with zero or load events are ignored for actions
package pwg_pkg;
    localparam logic [11:0] OFF_MCTL   = 12'h000;
    localparam logic [11:0] OFF_SYNC   = 12'h004;
    localparam logic [11:0] OFF_GATE   = 12'h008;
    localparam logic [11:0] OFF_POL    = 12'h00c;
    localparam logic [11:0] OFF_FAULT  = 12'h010;
    localparam logic [11:0] OFF_MIEN   = 12'h014;
    localparam logic [11:0] OFF_MRAW   = 12'h018;
    localparam logic [11:0] OFF_MISC   = 12'h01c;
    localparam logic [11:0] OFF_FLVL   = 12'h020;
    localparam logic [11:0] OFF_GCTL   = 12'h040;
    localparam logic [11:0] OFF_GIEN   = 12'h044;
    localparam logic [11:0] OFF_GRAW   = 12'h048;
    localparam logic [11:0] OFF_GISC   = 12'h04c;
    localparam logic [11:0] OFF_LOAD   = 12'h050;
    localparam logic [11:0] OFF_COUNT  = 12'h054;
    localparam logic [11:0] OFF_CMPA   = 12'h058;
    localparam logic [11:0] OFF_CMPB   = 12'h05c;
    localparam logic [11:0] OFF_ACTA   = 12'h060;
    localparam logic [11:0] OFF_ACTB   = 12'h064;
    localparam logic [11:0] OFF_DBCTL  = 12'h068;
    localparam logic [11:0] OFF_DBRISE = 12'h06c;
    localparam logic [11:0] OFF_DBFALL = 12'h070;
    // generator control fields
    localparam int CTL_RUN     = 0;
    localparam int CTL_UPDOWN  = 1;
    localparam int CTL_LOADUPD = 3;
    localparam int CTL_CMPAUPD = 4;
    localparam int CTL_CMPBUPD = 5;
    // module interrupt fields
    localparam int MI_GEN0  = 0;
    localparam int MI_FAULT = 16;
    // action field positions (two bits each)
    localparam int ACT_ZERO = 0;
    localparam int ACT_LOAD = 2;
    localparam int ACT_AUP  = 4;
    localparam int ACT_ADN  = 6;
    localparam int ACT_BUP  = 8;
    localparam int ACT_BDN  = 10;
    localparam logic [1:0] ACT_KEEP   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_LOW    = 2'h2;
    // reset values and widths
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic [2:0]  DIV_BY2     = 3'h0;
    localparam logic [2:0]  DIV_MAX_SH  = 3'h5;
    localparam logic [5:0]  DIV_FULL    = 6'h3f;
    localparam int          CNT_W       = 16;
    localparam int          DB_W        = 12;
    localparam int          EV_W        = 6;
endpackage

// ### tb/pwg_pin_model.sv
// gate driver stand-in: counts high samples and rising edges seen on both pins
`timescale 1ns/1ps
module pwg_pin_model (
    // clock and window restart
    input  wire logic   clk,
    input  wire logic   clr,
    // pins from the block
    input  wire logic   pin_a,
    input  wire logic   pin_b,
    // measurements over the window
    output logic [15:0] hi_a,
    output logic [15:0] hi_b,
    output logic [15:0] rise_a,
    output logic [15:0] rise_b
);
    logic prev_a;
    logic prev_b;
    always_ff @(posedge clk) begin
        prev_a <= pin_a;
        prev_b <= pin_b;
        if (clr) begin
            {hi_a, hi_b, rise_a, rise_b} <= 64'h0;
        end else begin
            hi_a   <= hi_a + 16'(pin_a);
            hi_b   <= hi_b + 16'(pin_b);
            rise_a <= rise_a + 16'(pin_a & !prev_a);
            rise_b <= rise_b + 16'(pin_b & !prev_b);
        end
    end
endmodule // pwg_pin_model

// ### tb/testbench.sv
// self-checking bench: register map, init example, gating, commit and restart
`timescale 1ns/1ps
module testbench
    import pwg_pkg::*;
;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clr = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q, c1;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp, pa, pb;
    logic [15:0] ha, hb, ra, rb;
    int          fails = 0, num_checks = 0, cyc = 0;
    // running clock stands for the module clock gate already switched on
    always #20 hclk = ~hclk;
    pwg_top i_pwg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clock_divider_code(3'h0),
        .clock_divider_use(1'b1), .fault_in(1'b0), .output_a_pin(pa), .output_b_pin(pb));
    pwg_pin_model i_pwg_pin_model (.clk(hclk), .clr(clr), .pin_a(pa), .pin_b(pb),
        .hi_a(ha), .hi_b(hb), .rise_a(ra), .rise_b(rb));
    task automatic report_and_stop;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            report_and_stop;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;  htrans <= 2'h2;  hwrite <= w;  haddr <= {20'h40028, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;  htrans <= 2'h0;  hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); bus(1, a, d); endtask
    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
        bus(0, a, 32'h0);
        chk(n, e, q);
        chk("okay resp", 32'h0, {31'h0, hresp});
    endtask
    task automatic measure(input logic [15:0] ea, eb, fa, fb);
        @(posedge hclk) clr <= 1;
        @(posedge hclk) clr <= 0;
        repeat (1600) @(posedge hclk);
        #1;
        chk("high a", 32'(ea), 32'(ha));
        chk("high b", 32'(eb), 32'(hb));
        chk("rises a", 32'(fa), 32'(ra));
        chk("rises b", 32'(fb), 32'(rb));
    endtask
    task automatic t_reset;
        for (int a = 0; a <= 'h70; a += 4)
            rd_chk("reset value", 12'(a), REG_RESET);
    endtask
    task automatic t_access;
        wr(OFF_POL, 32'hffff_ffff);
        rd_chk("reserved bits", OFF_POL, 32'h3);
        wr(OFF_POL, 32'h0);
        wr(OFF_COUNT, 32'h1234);
        rd_chk("counter ro", OFF_COUNT, 32'h0);
        wr(OFF_MISC, 32'hffff_ffff);
        rd_chk("status clear", OFF_MISC, 32'h0);
    endtask
    task automatic t_init;
        wr(OFF_GCTL, 32'h0);
        wr(OFF_ACTA, 32'h8c);
        wr(OFF_ACTB, 32'h80c);
        wr(OFF_LOAD, 32'h18f);
        wr(OFF_CMPA, 32'h12b);
        wr(OFF_CMPB, 32'h63);
        wr(OFF_GCTL, 32'h1);
        wr(OFF_GATE, 32'h3);
        repeat (800) @(posedge hclk);
        measure(400, 1200, 2, 2);
    endtask
    task automatic t_gate;
        wr(OFF_GATE, 32'h1);
        measure(400, 0, 2, 0);
        wr(OFF_GATE, 32'h0);
        wr(OFF_POL, 32'h3);
        measure(1600, 1600, 0, 0);
        bus(0, OFF_COUNT, 32'h0);
        c1 = q;
        bus(0, OFF_COUNT, 32'h0);
        chk("still counting", 32'h1, 32'(c1 !== q));
        wr(OFF_POL, 32'h0);
        wr(OFF_GATE, 32'h3);
        measure(400, 1200, 2, 2);
    endtask
    task automatic t_commit;
        wr(OFF_GCTL, 32'h19);
        wr(OFF_LOAD, 32'hc7);
        wr(OFF_MCTL, 32'h0);
        measure(400, 1200, 2, 2);
        wr(OFF_MCTL, 32'h1);
        repeat (900) @(posedge hclk);
        rd_chk("commit clears", OFF_MCTL, 32'h0);
        measure(1600, 800, 0, 4);
    endtask
    task automatic t_sync;
        wr(OFF_SYNC, 32'h1);
        bus(0, OFF_COUNT, 32'h0);
        chk("restarted", 32'h1, 32'(q[15:0] >= 16'h00c0 && q[15:0] <= 16'h00c7));
        rd_chk("sync clears", OFF_SYNC, 32'h0);
    endtask
    // counter stopped first so no new event can set a status bit again
    task automatic t_status;
        wr(OFF_GIEN, 32'h1);
        wr(OFF_GCTL, 32'h18);
        rd_chk("gen status", OFF_GISC, 32'h1);
        rd_chk("module raw", OFF_MRAW, 32'h1);
        wr(OFF_GRAW, 32'h0);
        rd_chk("raw read only", OFF_GRAW, 32'h2b);
        wr(OFF_GISC, 32'h1);
        rd_chk("gen cleared", OFF_GISC, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        t_reset;
        t_access;
        t_init;
        t_gate;
        t_commit;
        t_sync;
        t_status;
        report_and_stop;
    end
endmodule // testbench
